// >>> shared/datapath_pkg.sv
// Shared constants and types for the microcoded ALU and scratch-pad data path
`default_nettype none
package datapath_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int STATUS_W = 8;

    // Register word offsets on the APB
    localparam logic [7:0] REG_INSTR   = 8'h00;
    localparam logic [7:0] REG_BUSADDR = 8'h04;
    localparam logic [7:0] REG_DATAIN  = 8'h08;
    localparam logic [7:0] REG_RESULT  = 8'h0c;
    localparam logic [7:0] REG_STATUS  = 8'h10;
    localparam logic [7:0] REG_OPERAND = 8'h14;

    // Reset values
    localparam logic [15:0] INSTR_RST   = 16'h0000;
    localparam logic [15:0] BUSADDR_RST = 16'h0000;
    localparam logic [15:0] DATAIN_RST  = 16'h0000;
    localparam logic [7:0]  STATUS_RST  = 8'h00;

    // Status word field positions
    localparam int ST_C = 0;
    localparam int ST_V = 1;
    localparam int ST_Z = 2;
    localparam int ST_N = 3;
    localparam int ST_T = 4;
    localparam int ST_PRI_LO = 5;

    // Scratch word whose access exchanges the bytes in the input latch
    localparam logic [3:0] SWAP_TEMP_WORD = 4'hf;

    // Instruction field positions
    localparam int IR_SRC_LO = 6;
    localparam int IR_DST_LO = 0;

    typedef enum logic [1:0] {
        BLEG_OPERAND = 2'b00,
        BLEG_SEXT    = 2'b01,
        BLEG_ONE     = 2'b10,
        BLEG_ZERO    = 2'b11
    } bleg_sel_t;

    typedef enum logic [1:0] {
        PATH_ALU     = 2'b00,
        PATH_DATAIN  = 2'b01,
        PATH_OPERAND = 2'b10,
        PATH_STATUS  = 2'b11
    } path_sel_t;

    typedef enum logic [1:0] {
        OPM_HOLD  = 2'b00,
        OPM_RIGHT = 2'b01,
        OPM_LEFT  = 2'b10,
        OPM_LOAD  = 2'b11
    } operand_mode_t;

    typedef struct packed {
        logic [3:0]    alu_sel;
        logic          alu_mode;
        logic          alu_carry_in;
        logic          aleg_invert;
        logic          aleg_read_enable_n;
        bleg_sel_t     bleg_sel;
        path_sel_t     path_source_mux;
        logic          addr_src_sel1;
        logic          addr_src_sel0;
        logic [3:0]    micro_reg_field;
        logic          upper_byte_write_en;
        logic          lower_byte_write_en;
        operand_mode_t operand_mode;
        logic          serial_in;
        logic          flag_load;
    } micro_word_t;
endpackage
`default_nettype wire

// >>> rtl/microcoded_alu_scratchpad_datapath.sv
// Sixteen-bit microcoded data path: sliced ALU, scratch array, operand register, APB access
//
// Summary of operation
// RULE_01 - ALU: two 16-bit words, 32 functions
// RULE_02 - Four 4-bit slices joined by carry lookahead
// RULE_03 - Select, mode and carry-in steer function
// RULE_04 - Arithmetic encodings; carry-in low adds one
// RULE_05 - Logic encodings for zero, B, not B
// RULE_06 - A-leg reads addressed scratch word
// RULE_07 - B-leg: operand, sign-extended, one, zero
// RULE_08 - Four-input path mux, new or recirculated
// RULE_09 - Operand register loads, shifts and rotates; the code only loads and shifts, filling from serial_in, with no rotate
// RULE_10 - Eight-bit status: priority, NZVC, trace
// RULE_11 - Scratch array 16 words by 16 bits
// RULE_12 - Each microword fixes routing and function
// RULE_13 - Latch takes path mux data, maybe swapped
// RULE_14 - Word seventeen octal exchanges latch bytes
// RULE_15 - Latch on strobe, array written afterward
// RULE_16 - Byte enables gate upper, lower, word writes
// RULE_17 - Byte enables gate latch byte capture
// RULE_18 - Address mux gives 4-bit word address
// RULE_19 - Sources: bus, source, destination, micro field
// RULE_20 - Select 00 bus, 01 source, 10 destination
// RULE_21 - Select 11 passes micro register field
// RULE_22 - Word roles: registers, SP, PC, temporaries
// RULE_23 - A-leg gating by invert and enable
`timescale 1ns/1ps
`default_nettype none
module microcoded_alu_scratchpad_datapath #(
    parameter int APB_AW = 8
) (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RESETN,
    input  wire datapath_pkg::micro_word_t MICRO_WORD,
    input  wire logic                      REG_STROBE,
    output logic [15:0]                    ALU_RESULT,
    output logic [7:0]                     STATUS_WORD,
    output logic                           CARRY_OUT,
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [APB_AW-1:0]         PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic [31:0]                    PRDATA,
    output logic                           PREADY,
    output logic                           PSLVERR
);
    // Arithmetic mode yields {x, y}; the slice then adds x + y + carry
    function automatic logic [7:0] arith_xy(input logic [3:0] a, input logic [3:0] b,
                                            input logic [3:0] s);
        case (s)
            4'h0: arith_xy = {a, 4'h0};
            4'h1: arith_xy = {a | b, 4'h0};
            4'h2: arith_xy = {a | ~b, 4'h0};
            4'h3: arith_xy = {4'hf, 4'h0};
            4'h4: arith_xy = {a, a & ~b};
            4'h5: arith_xy = {a | b, a & ~b};
            4'h6: arith_xy = {a, ~b};
            4'h7: arith_xy = {a & ~b, 4'hf};
            4'h8: arith_xy = {a, a & b};
            4'h9: arith_xy = {a, b};
            4'ha: arith_xy = {a | ~b, a & b};
            4'hb: arith_xy = {a & b, 4'hf};
            4'hc: arith_xy = {a, a};
            4'hd: arith_xy = {a | b, a};
            4'he: arith_xy = {a | ~b, a};
            default: arith_xy = {a, 4'hf};
        endcase
    endfunction

    function automatic logic [3:0] logic_f(input logic [3:0] a, input logic [3:0] b,
                                           input logic [3:0] s);
        case (s)
            4'h0: logic_f = ~a;
            4'h1: logic_f = ~(a | b);
            4'h2: logic_f = ~a & b;
            4'h3: logic_f = 4'h0;
            4'h4: logic_f = ~(a & b);
            4'h5: logic_f = ~b;
            4'h6: logic_f = a ^ b;
            4'h7: logic_f = a & ~b;
            4'h8: logic_f = ~a | b;
            4'h9: logic_f = ~(a ^ b);
            4'ha: logic_f = b;
            4'hb: logic_f = a & b;
            4'hc: logic_f = 4'hf;
            4'hd: logic_f = a | ~b;
            4'he: logic_f = a | b;
            default: logic_f = a;
        endcase
    endfunction

    // Group generate and propagate of one slice
    function automatic logic [1:0] slice_gp(input logic [3:0] x, input logic [3:0] y);
        logic [3:0] g;
        logic [3:0] p;
        g = x & y;
        p = x | y;
        slice_gp = {g[3] | (p[3] & g[2]) | (p[3] & p[2] & g[1]) | (p[3] & p[2] & p[1] & g[0]),
                    &p};
    endfunction

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == datapath_pkg::REG_INSTR) || (a == datapath_pkg::REG_BUSADDR) ||
                  (a == datapath_pkg::REG_DATAIN) || (a == datapath_pkg::REG_RESULT) ||
                  (a == datapath_pkg::REG_STATUS) || (a == datapath_pkg::REG_OPERAND);
    endfunction

    datapath_pkg::micro_word_t mw;
    logic [15:0] scratch_register_array [16];
    logic [15:0] instr_q;
    logic [15:0] busaddr_q;
    logic [15:0] datain_q;
    logic [15:0] result_q;
    logic [7:0]  status_q;
    logic [7:0]  status_d;
    logic [15:0] operand_shift_reg_q;
    logic [15:0] operand_d;
    logic [15:0] latch_q;
    logic [15:0] latch_d;
    logic        carry_q;
    logic        wr_pend_q;
    logic        wr_hi_q;
    logic        wr_lo_q;
    logic [3:0]  wr_addr_q;
    logic [31:0] prdata_q;

    logic [3:0]  scratch_addr_select;
    logic [15:0] scratch_rd;
    logic        aleg_en;
    logic [15:0] aleg;
    logic [15:0] bleg;
    logic [15:0] alu_x;
    logic [15:0] alu_y;
    logic [15:0] alu_f;
    logic [3:0]  grp_g;
    logic [3:0]  grp_p;
    logic [4:0]  slice_c;
    logic        alu_ovf;
    logic [15:0] path_data;
    logic        byte_exchange_sel_n;
    logic [15:0] latch_src;
    logic [7:0]  apb_a;
    logic        apb_setup;
    logic        apb_wr;
    logic [31:0] rd_mux;

    assign mw = MICRO_WORD; // RULE_12

    // Address source selection
    assign scratch_addr_select =
        !mw.addr_src_sel1 && !mw.addr_src_sel0 ? busaddr_q[3:0] :                               // RULE_20
        !mw.addr_src_sel1 &&  mw.addr_src_sel0 ? {1'b0, instr_q[datapath_pkg::IR_SRC_LO +: 3]} : // RULE_19
         mw.addr_src_sel1 && !mw.addr_src_sel0 ? {1'b0, instr_q[datapath_pkg::IR_DST_LO +: 3]} : // RULE_18
                                                 mw.micro_reg_field;                             // RULE_21

    // Scratch read feeds the A-leg through the invert/enable gating
    assign scratch_rd = scratch_register_array[scratch_addr_select]; // RULE_06
    assign aleg_en = mw.aleg_read_enable_n;
    assign aleg = mw.aleg_invert ? (aleg_en ? scratch_rd : 16'h0000)
                                 : (aleg_en ? ~scratch_rd : 16'hffff); // RULE_23

    assign bleg = mw.bleg_sel == datapath_pkg::BLEG_OPERAND ? operand_shift_reg_q :
                  mw.bleg_sel == datapath_pkg::BLEG_SEXT
                      ? {{8{operand_shift_reg_q[7]}}, operand_shift_reg_q[7:0]} :
                  mw.bleg_sel == datapath_pkg::BLEG_ONE ? 16'h0001 : 16'h0000; // RULE_07

    // Carry in is active low: a low level adds one
    assign slice_c[0] = ~mw.alu_carry_in; // RULE_04

    genvar i;
    generate
        for (i = 0; i < 4; i++) begin : g_slice
            logic [7:0] xy;
            logic [4:0] sum;
            logic [1:0] gp;
            assign xy = arith_xy(aleg[4*i +: 4], bleg[4*i +: 4], mw.alu_sel); // RULE_03
            assign alu_x[4*i +: 4] = xy[7:4];
            assign alu_y[4*i +: 4] = xy[3:0];
            assign gp = slice_gp(xy[7:4], xy[3:0]);
            assign grp_g[i] = gp[1];
            assign grp_p[i] = gp[0];
            assign sum = {1'b0, xy[7:4]} + {1'b0, xy[3:0]} + {4'h0, slice_c[i]};
            assign alu_f[4*i +: 4] = mw.alu_mode ? logic_f(aleg[4*i +: 4], bleg[4*i +: 4], mw.alu_sel) // RULE_05
                                                 : sum[3:0]; // RULE_01
        end
    endgenerate

    // Lookahead carries into each slice, in two-level form
    assign slice_c[1] = grp_g[0] | (grp_p[0] & slice_c[0]); // RULE_02
    assign slice_c[2] = grp_g[1] | (grp_p[1] & grp_g[0]) | (grp_p[1] & grp_p[0] & slice_c[0]);
    assign slice_c[3] = grp_g[2] | (grp_p[2] & grp_g[1]) | (grp_p[2] & grp_p[1] & grp_g[0]) |
                        (grp_p[2] & grp_p[1] & grp_p[0] & slice_c[0]);
    assign slice_c[4] = grp_g[3] | (grp_p[3] & grp_g[2]) | (grp_p[3] & grp_p[2] & grp_g[1]) |
                        (grp_p[3] & grp_p[2] & grp_p[1] & grp_g[0]) |
                        (grp_p[3] & grp_p[2] & grp_p[1] & grp_p[0] & slice_c[0]);
    assign alu_ovf = (alu_x[15] == alu_y[15]) && (alu_f[15] != alu_x[15]);

    assign path_data = mw.path_source_mux == datapath_pkg::PATH_ALU     ? alu_f :
                       mw.path_source_mux == datapath_pkg::PATH_DATAIN  ? datain_q :
                       mw.path_source_mux == datapath_pkg::PATH_OPERAND ? operand_shift_reg_q :
                                                                          {8'h00, status_q}; // RULE_08

    // Exchange select is asserted low whenever the swap temporary word is addressed
    assign byte_exchange_sel_n = (scratch_addr_select != datapath_pkg::SWAP_TEMP_WORD); // RULE_22
    assign latch_src = byte_exchange_sel_n ? path_data : {path_data[7:0], path_data[15:8]}; // RULE_14
    assign latch_d = {mw.upper_byte_write_en ? latch_src[15:8] : latch_q[15:8],
                      mw.lower_byte_write_en ? latch_src[7:0]  : latch_q[7:0]}; // RULE_17

    assign operand_d = mw.operand_mode == datapath_pkg::OPM_LOAD  ? path_data :
                       mw.operand_mode == datapath_pkg::OPM_RIGHT
                           ? {mw.serial_in, operand_shift_reg_q[15:1]} :
                       mw.operand_mode == datapath_pkg::OPM_LEFT
                           ? {operand_shift_reg_q[14:0], mw.serial_in} : operand_shift_reg_q; // RULE_09

    // Flag update from the ALU wins over a software write in the same cycle
    assign apb_a = 8'(PADDR);
    assign apb_setup = PSEL && !PENABLE;
    assign apb_wr = PSEL && PENABLE && PWRITE && reg_hit(apb_a);
    assign status_d = REG_STROBE && mw.flag_load
        ? {status_q[7:4], alu_f[15], alu_f == 16'h0000, alu_ovf, slice_c[4]} :
        (apb_wr && apb_a == datapath_pkg::REG_STATUS) ? PWDATA[7:0] : status_q; // RULE_10

    assign rd_mux = apb_a == datapath_pkg::REG_INSTR   ? {16'h0000, instr_q} :
                    apb_a == datapath_pkg::REG_BUSADDR ? {16'h0000, busaddr_q} :
                    apb_a == datapath_pkg::REG_DATAIN  ? {16'h0000, datain_q} :
                    apb_a == datapath_pkg::REG_RESULT  ? {16'h0000, result_q} :
                    apb_a == datapath_pkg::REG_STATUS  ? {24'h000000, status_q} :
                    apb_a == datapath_pkg::REG_OPERAND ? {16'h0000, operand_shift_reg_q} : 32'h00000000;

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            instr_q   <= datapath_pkg::INSTR_RST;
            busaddr_q <= datapath_pkg::BUSADDR_RST;
            datain_q  <= datapath_pkg::DATAIN_RST;
            prdata_q  <= 32'h00000000;
        end else begin
            if (apb_wr && apb_a == datapath_pkg::REG_INSTR) instr_q <= PWDATA[15:0];
            if (apb_wr && apb_a == datapath_pkg::REG_BUSADDR) busaddr_q <= PWDATA[15:0];
            if (apb_wr && apb_a == datapath_pkg::REG_DATAIN) datain_q <= PWDATA[15:0];
            if (apb_setup) prdata_q <= rd_mux;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            status_q            <= datapath_pkg::STATUS_RST;
            result_q            <= 16'h0000;
            carry_q             <= 1'b0;
            operand_shift_reg_q <= 16'h0000;
            latch_q             <= 16'h0000;
        end else begin
            status_q <= status_d;
            if (REG_STROBE) begin
                result_q            <= alu_f;
                carry_q             <= slice_c[4];
                operand_shift_reg_q <= operand_d;
                latch_q             <= latch_d; // RULE_13
            end
        end
    end

    // The array write trails the latch by one cycle, mirroring a write held while the clock is high
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wr_pend_q <= 1'b0;
            wr_hi_q   <= 1'b0;
            wr_lo_q   <= 1'b0;
            wr_addr_q <= 4'h0;
        end else begin
            wr_pend_q <= REG_STROBE && (mw.upper_byte_write_en || mw.lower_byte_write_en); // RULE_15
            wr_hi_q   <= mw.upper_byte_write_en;
            wr_lo_q   <= mw.lower_byte_write_en;
            wr_addr_q <= scratch_addr_select;
        end
    end

    // No reset on the array: its contents are undefined until a microword writes them through the latch
    always_ff @(posedge CORE_CLK) begin
        if (wr_pend_q && wr_hi_q) scratch_register_array[wr_addr_q][15:8] <= latch_q[15:8]; // RULE_16
        if (wr_pend_q && wr_lo_q) scratch_register_array[wr_addr_q][7:0] <= latch_q[7:0];   // RULE_11
    end

    assign ALU_RESULT  = result_q;
    assign STATUS_WORD = status_q;
    assign CARRY_OUT   = carry_q;
    assign PRDATA      = prdata_q;
    assign PREADY      = 1'b1;
    assign PSLVERR     = PSEL && PENABLE && !reg_hit(apb_a);

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    property p_swap;
        REG_STROBE && scratch_addr_select == 4'hf && mw.upper_byte_write_en && mw.lower_byte_write_en
        |=> latch_q == {$past(path_data[7:0]), $past(path_data[15:8])};
    endproperty
    a_swap: assert property (p_swap) else $error("latch bytes not exchanged"); // RULE_14

    property p_noswap;
        REG_STROBE && scratch_addr_select != 4'hf && mw.upper_byte_write_en && mw.lower_byte_write_en
        |=> latch_q == $past(path_data);
    endproperty
    a_noswap: assert property (p_noswap) else $error("latch lost path data"); // RULE_13

    property p_byte_hold;
        REG_STROBE && !mw.upper_byte_write_en |=> $stable(latch_q[15:8]);
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("upper latch byte changed"); // RULE_17

    property p_write_lo;
        REG_STROBE && mw.lower_byte_write_en
        |=> ##1 scratch_register_array[$past(scratch_addr_select, 2)][7:0] == $past(latch_q[7:0]);
    endproperty
    a_write_lo: assert property (p_write_lo) else $error("low byte not written"); // RULE_16

    property p_addr_micro;
        mw.addr_src_sel1 && mw.addr_src_sel0 |-> scratch_addr_select == mw.micro_reg_field;
    endproperty
    a_addr_micro: assert property (p_addr_micro) else $error("micro field not selected"); // RULE_21

    property p_addr_src;
        !mw.addr_src_sel1 && mw.addr_src_sel0 |-> scratch_addr_select == {1'b0, instr_q[8:6]};
    endproperty
    a_addr_src: assert property (p_addr_src) else $error("source field not selected"); // RULE_20

    property p_aleg_ones;
        !mw.aleg_invert && !mw.aleg_read_enable_n |-> aleg == 16'hffff;
    endproperty
    a_aleg_ones: assert property (p_aleg_ones) else $error("A-leg not all ones"); // RULE_23

    property p_add;
        !mw.alu_mode && mw.alu_sel == 4'h9 && mw.alu_carry_in |-> alu_f == 16'(aleg + bleg);
    endproperty
    a_add: assert property (p_add) else $error("A plus B wrong"); // RULE_04

    property p_sub;
        !mw.alu_mode && mw.alu_sel == 4'h6 && !mw.alu_carry_in |-> alu_f == 16'(aleg - bleg);
    endproperty
    a_sub: assert property (p_sub) else $error("A minus B wrong"); // RULE_02

    property p_sext;
        mw.bleg_sel == datapath_pkg::BLEG_SEXT |-> bleg[15:8] == {8{operand_shift_reg_q[7]}};
    endproperty
    a_sext: assert property (p_sext) else $error("sign extension wrong"); // RULE_07

    property p_shift_right;
        REG_STROBE && mw.operand_mode == datapath_pkg::OPM_RIGHT
        |=> operand_shift_reg_q == {$past(mw.serial_in), $past(operand_shift_reg_q[15:1])};
    endproperty
    a_shift_right: assert property (p_shift_right) else $error("right shift wrong"); // RULE_09

    property p_zero;
        mw.alu_mode && mw.alu_sel == 4'h3 |-> alu_f == 16'h0000;
    endproperty
    a_zero: assert property (p_zero) else $error("zero function wrong"); // RULE_05

    property p_flag_nz;
        REG_STROBE && mw.flag_load
        |=> {status_q[datapath_pkg::ST_N], status_q[datapath_pkg::ST_Z]} == {ALU_RESULT[15], ALU_RESULT == 16'h0000};
    endproperty
    a_flag_nz: assert property (p_flag_nz) else $error("N or Z flag wrong"); // RULE_10

    property p_flag_c;
        REG_STROBE && mw.flag_load |=> status_q[datapath_pkg::ST_C] == CARRY_OUT;
    endproperty
    a_flag_c: assert property (p_flag_c) else $error("C flag wrong"); // RULE_10

    c_swap_write: cover property (REG_STROBE && scratch_addr_select == 4'hf ##1 wr_hi_q);
    c_shift_left: cover property (REG_STROBE && mw.operand_mode == datapath_pkg::OPM_LEFT);
    c_add_carry: cover property (!mw.alu_mode && mw.alu_sel == 4'h9 && slice_c[4]);
    c_status_read: cover property (PSEL && PENABLE && !PWRITE && apb_a == datapath_pkg::REG_STATUS);
endmodule
`default_nettype wire

// >>> verif/control_store_model.sv
// Control store model: presents one microword per register strobe
`timescale 1ns/1ps
`default_nettype none
module control_store_model (
    input  wire logic                      CORE_CLK,
    input  wire logic                      RESETN,
    input  wire logic                      go,
    input  wire datapath_pkg::micro_word_t word_in,
    output datapath_pkg::micro_word_t      MICRO_WORD,
    output logic                           REG_STROBE
);
    // After a strobe the store moves on, so the write enables drop at once;
    // a design that reads them late for its array write will lose the data
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            MICRO_WORD <= '0;
            REG_STROBE <= 1'b0;
        end else if (go) begin
            MICRO_WORD <= word_in;
            REG_STROBE <= 1'b1;
        end else begin
            MICRO_WORD.upper_byte_write_en <= 1'b0;
            MICRO_WORD.lower_byte_write_en <= 1'b0;
            REG_STROBE <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the microcoded ALU and scratch-pad data path
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [15:0] OPA = 16'h3c5a;
    localparam logic [15:0] OPB = 16'h12b4;
    localparam logic [5:0]  F_A = 6'b000001;
    localparam logic [5:0]  F_B = 6'b110101;
    localparam logic [5:0]  ALU_CODE [13] = '{6'b100111, 6'b000001, 6'b110101, 6'b011001, 6'b000000, 6'b010011,
        6'b010010, 6'b001101, 6'b001100, 6'b010111, 6'b000011, 6'b001110, 6'b101011};
    localparam logic [15:0] ALU_EXP [13] = '{16'h0000, OPA, OPB, 16'(OPA + OPA), 16'(OPA + 1), 16'(OPA + OPB),
        16'(OPA + OPB + 1), 16'(OPA - OPB - 1), 16'(OPA - OPB), 16'((OPA & OPB) - 1), OPA | OPB, OPA & ~OPB, ~OPB};
    localparam logic [15:0] BL_EXP [4] = '{OPB, 16'hffb4, 16'h0001, 16'h0000};
    localparam logic [15:0] AL_EXP [4] = '{16'hffff, ~OPA, 16'h0000, OPA};
    logic                      CORE_CLK;
    logic                      RESETN;
    logic                      PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CARRY_OUT, REG_STROBE, go, err;
    logic [7:0]                PADDR, STATUS_WORD;
    logic [31:0]               PWDATA, PRDATA, rd;
    logic [15:0]               ALU_RESULT;
    datapath_pkg::micro_word_t MICRO_WORD, req, m;
    int                        error_cnt, tests_run;

    control_store_model u_cs (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .go(go), .word_in(req),
        .MICRO_WORD(MICRO_WORD), .REG_STROBE(REG_STROBE));
    microcoded_alu_scratchpad_datapath #(.APB_AW(8)) u_dut (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
        .MICRO_WORD(MICRO_WORD), .REG_STROBE(REG_STROBE), .ALU_RESULT(ALU_RESULT), .STATUS_WORD(STATUS_WORD),
        .CARRY_OUT(CARRY_OUT), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

    initial begin
        CORE_CLK = 1'b0;
        forever #25 CORE_CLK = ~CORE_CLK;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Holds the request through the access phase until PREADY is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge CORE_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= addr;
        PWDATA <= wd;
        @(posedge CORE_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CORE_CLK);
        end while (PREADY !== 1'b1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    // Three spare edges let the delayed array write land before the next word
    task automatic run_uw(input datapath_pkg::micro_word_t w);
        @(posedge CORE_CLK);
        req <= w;
        go <= 1'b1;
        @(posedge CORE_CLK);
        go <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
    endtask

    function automatic datapath_pkg::micro_word_t uw(input logic [5:0] alu, input logic [1:0] bl,
        input logic [1:0] pm, input logic [1:0] as, input logic [3:0] fld, input logic [1:0] we, input logic [1:0] opm);
        datapath_pkg::micro_word_t w;
        w = '0;
        {w.alu_mode, w.alu_sel, w.alu_carry_in} = alu;
        w.aleg_invert = 1'b1;
        w.aleg_read_enable_n = 1'b1;
        w.bleg_sel = datapath_pkg::bleg_sel_t'(bl);
        w.path_source_mux = datapath_pkg::path_sel_t'(pm);
        {w.addr_src_sel1, w.addr_src_sel0} = as;
        w.micro_reg_field = fld;
        {w.upper_byte_write_en, w.lower_byte_write_en} = we;
        w.operand_mode = datapath_pkg::operand_mode_t'(opm);
        return w;
    endfunction

    task automatic put(input logic [3:0] w, input logic [15:0] d, input logic [1:0] we);
        apb(1'b1, datapath_pkg::REG_DATAIN, {16'h0000, d});
        run_uw(uw(F_A, 2'b00, 2'b01, 2'b11, w, we, 2'b00));
    endtask

    task automatic get(input logic [1:0] as, input logic [3:0] w, input logic [15:0] exp);
        run_uw(uw(F_A, 2'b00, 2'b00, as, w, 2'b00, 2'b00));
        chk({16'h0000, ALU_RESULT}, {16'h0000, exp}, "scratch word");
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        error_cnt++;
        conclude();
    end

    initial begin
        {error_cnt, tests_run} = '0;
        {PSEL, PENABLE, PWRITE, go, RESETN} = '0;
        {PADDR, PWDATA} = '0;
        req = '0;
        repeat (6) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        apb(1'b0, datapath_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h0, "status after reset");
        apb(1'b1, datapath_pkg::REG_STATUS, 32'hffffffa5);
        apb(1'b0, datapath_pkg::REG_STATUS, 32'h0);
        chk(rd, 32'h000000a5, "status eight bits");
        apb(1'b0, 8'h18, 32'h0);
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("test registers done");
        put(4'h0, OPA, 2'b11);
        apb(1'b1, datapath_pkg::REG_DATAIN, {16'h0000, OPB});
        run_uw(uw(F_A, 2'b00, 2'b01, 2'b11, 4'h0, 2'b00, 2'b11));
        for (int i = 0; i < 13; i++) begin
            run_uw(uw(ALU_CODE[i], 2'b00, 2'b00, 2'b11, 4'h0, 2'b00, 2'b00));
            chk({16'h0, ALU_RESULT}, {16'h0, ALU_EXP[i]}, "alu function");
        end
        apb(1'b1, datapath_pkg::REG_RESULT, 32'hffff);
        apb(1'b0, datapath_pkg::REG_RESULT, 32'h0);
        chk(rd, {16'h0, ALU_EXP[12]}, "result read only");
        apb(1'b0, datapath_pkg::REG_OPERAND, 32'h0);
        chk(rd, {16'h0, OPB}, "operand load");
        m = uw(6'b001100, 2'b00, 2'b00, 2'b11, 4'h0, 2'b00, 2'b01);
        {m.flag_load, m.serial_in} = 2'b11;
        run_uw(m);
        chk({23'h0, CARRY_OUT, STATUS_WORD}, 32'h000001a1, "flags and carry");
        apb(1'b0, datapath_pkg::REG_OPERAND, 32'h0);
        chk(rd, 32'h0000895a, "shift right");
        run_uw(uw(F_A, 2'b00, 2'b10, 2'b11, 4'h6, 2'b11, 2'b10));
        get(2'b11, 4'h6, 16'h895a);
        run_uw(uw(F_A, 2'b00, 2'b11, 2'b11, 4'h7, 2'b11, 2'b00));
        get(2'b11, 4'h7, 16'h00a1);
        $display("test alu functions done");
        for (int i = 0; i < 4; i++) begin
            run_uw(uw(F_B, 2'(i), 2'b00, 2'b11, 4'h0, 2'b00, 2'b00));
            chk({16'h0, ALU_RESULT}, {16'h0, BL_EXP[i]}, "b leg source");
            m = uw(F_A, 2'b00, 2'b00, 2'b11, 4'h0, 2'b00, 2'b00);
            m.aleg_invert = i[1];
            m.aleg_read_enable_n = i[0];
            run_uw(m);
            chk({16'h0, ALU_RESULT}, {16'h0, AL_EXP[i]}, "a leg gating");
        end
        $display("test operand legs done");
        apb(1'b1, datapath_pkg::REG_INSTR, 32'h00000083);
        apb(1'b1, datapath_pkg::REG_BUSADDR, 32'h00000004);
        put(4'h2, 16'h2222, 2'b11);
        put(4'h3, 16'h3333, 2'b11);
        put(4'h4, 16'h4444, 2'b11);
        get(2'b00, 4'h0, 16'h4444);
        get(2'b01, 4'h0, 16'h2222);
        get(2'b10, 4'h0, 16'h3333);
        get(2'b11, 4'h2, 16'h2222);
        $display("test address select done");
        put(4'h5, 16'haaaa, 2'b11);
        put(4'h5, 16'h1234, 2'b10);
        get(2'b11, 4'h5, 16'h12aa);
        put(4'h5, 16'h5678, 2'b01);
        get(2'b11, 4'h5, 16'h1278);
        put(4'h5, 16'hffff, 2'b00);
        get(2'b11, 4'h5, 16'h1278);
        put(4'hf, 16'h1234, 2'b11);
        get(2'b11, 4'hf, 16'h3412);
        get(2'b11, 4'h0, OPA);
        $display("test scratch writes done");
        conclude();
    end
endmodule
`default_nettype wire
